// *** mcm_pkg.sv ***
/*
 * constants for the monitor configuration and mask register bank:
 * register offsets, field positions, reset values, channel codes and timing.
 * assumes an 8-bit register access port driven by a serial front end.
 */
package mcm_pkg;
   // ***************************************************************
   // register offsets
   // ***************************************************************
   localparam logic [7:0] ADDR_CTRL_A = 8'h18; // first control register
   localparam logic [7:0] ADDR_CTRL_B = 8'h19;
   localparam logic [7:0] ADDR_CTRL_C = 8'h1a;
   localparam logic [7:0] ADDR_MASK_LO = 8'h1d;
   localparam logic [7:0] ADDR_MASK_HI = 8'h1e;
   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [7:0] RST_CTRL_A = 8'h08;
   localparam logic [7:0] RST_CTRL_B = 8'h00;
   localparam logic [7:0] RST_CTRL_C = 8'h08;
   localparam logic [7:0] RST_MASK = 8'h00;
   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int A_MON_EN = 0;   // monitoring enable
   localparam int A_PAIR_LO = 1;  // pin-pair field low bit
   localparam int A_INT_DIS = 5;  // interrupt output disable
   localparam int A_INT_POL = 6;  // interrupt polarity
   localparam int B_SEL_LO = 0;   // channel select, four bits
   localparam int B_SINGLE = 4;   // single-channel mode
   localparam int B_AVG_DIS = 5;  // averaging disable
   localparam int B_TO_EN = 6;    // serial-clock timeout enable
   localparam int B_SW_RST = 7;   // software reset
   localparam int C_FAST = 0;     // fast adc clock
   localparam int C_REF_VDD = 4;  // supply as reference
   // ***************************************************************
   // channel codes and pin-pair codes
   // ***************************************************************
   localparam logic [3:0] CH_SUPPLY = 4'h0;
   localparam logic [3:0] CH_INT_TEMP = 4'h1;
   localparam logic [3:0] CH_EXT_OR_ANALOG_INPUT_ONE = 4'h2;
   localparam logic [3:0] CH_LAST = 4'h9;
   localparam logic [1:0] PAIR_ANALOG = 2'h0;
   localparam logic [1:0] PAIR_DIODE = 2'h2;
   // target codes: 0 supply,1 int temp,2 ext diode,3..10 analog one..eight
   localparam logic [3:0] TGT_EXT_DIODE = 4'h2;
   localparam logic [3:0] TGT_ANALOG_INPUT_ONE = 4'h3;
   localparam logic [3:0] TGT_NONE = 4'hf;
   localparam logic [4:0] AVG_COUNT = 5'h10; // samples per result
   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_HZ = 100_000_000;
   localparam int TIMEOUT_MS = 25;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int ADC_NORM_DHZ = 14;   // 1.4 Hz in tenths of hertz
   localparam int ADC_FAST_DHZ = 225;  // 22.5 Hz in tenths of hertz
   localparam int ADC_NORM_HALF = (CLK_HZ * 10) / (ADC_NORM_DHZ * 2);
   localparam int ADC_FAST_HALF = (CLK_HZ * 10) / (ADC_FAST_DHZ * 2);
endpackage : mcm_pkg

// *** mcm_adc_clk.sv ***
/*
 * adc clock divider: toggles its output every half-period count.
 * assumes half counts supplied by the parent, at least one.
 */
`timescale 1ns/100ps
`default_nettype none
module mcm_adc_clk #(
   parameter int CW = 20
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic run,
   input wire logic [CW-1:0] half,
   output logic adc_clk
);
   logic [CW-1:0] cnt; // cycles into the current half period
   // ***************************************************************
   // divider
   // ***************************************************************
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= '0;
         adc_clk <= 1'b0;
      end else if (!run) begin
         cnt <= '0;
         adc_clk <= 1'b0;
      end else if (cnt >= half - CW'(1)) begin
         cnt <= '0;
         adc_clk <= ~adc_clk;
      end else begin
         cnt <= cnt + CW'(1);
      end
   end
endmodule : mcm_adc_clk
`default_nettype wire

// *** mcm_regs.sv ***
/*
 * configuration and event mask register bank of the monitor.
 * assumes a serial front end giving one-cycle write and read strobes
 * with an 8-bit address, plus the sampled serial clock level.
 */
`timescale 1ns/100ps
`default_nettype none
module mcm_regs #(
   parameter int TIMEOUT_CYCLES = mcm_pkg::TIMEOUT_CYC
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic wr_en,            // write strobe
   input wire logic rd_en,            // read strobe
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,          // registered read data
   output logic rvalid,               // read answer pulse
   input wire logic scl_in,           // serial clock level
   input wire logic xfer_active,      // serial transaction in progress
   output logic xfer_abort,           // timeout pulse to front end
   input wire logic [12:0] events,    // raw limit and fault events
   output logic int_out,              // interrupt pin level
   output logic int_oe,               // interrupt pin enable
   output logic conv_run,             // conversions running
   output logic conv_single,          // single-channel sequencing
   output logic [3:0] conv_target,    // converted input code
   output logic [4:0] avg_samples,    // samples averaged per result
   output logic fast_speed,
   output logic diode_filter_bypass,
   output logic ref_is_supply,
   output logic adc_clk
);
   // ***************************************************************
   // registers
   // ***************************************************************
   logic [7:0] ctrl_a;  // first control register
   logic [7:0] conversion_control_b;
   logic [7:0] conversion_control_c;
   logic [7:0] event_mask_low;
   logic [7:0] event_mask_high;
   logic sw_reset;      // software reset request
   logic [3:0] next_target;
   logic [31:0] to_cnt; // cycles since scl last moved
   logic scl_q;         // previous scl sample
   logic [12:0] mask_all;

   assign sw_reset = wr_en && addr == mcm_pkg::ADDR_CTRL_B && wdata[mcm_pkg::B_SW_RST];
   assign mask_all = {event_mask_high[4:0], event_mask_low};

   // register writes; software reset reloads every default
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ctrl_a <= mcm_pkg::RST_CTRL_A;
         conversion_control_b <= mcm_pkg::RST_CTRL_B;
         conversion_control_c <= mcm_pkg::RST_CTRL_C;
         event_mask_low <= mcm_pkg::RST_MASK;
         event_mask_high <= mcm_pkg::RST_MASK;
      end else if (sw_reset) begin
         ctrl_a <= mcm_pkg::RST_CTRL_A;
         conversion_control_b <= mcm_pkg::RST_CTRL_B;
         conversion_control_c <= mcm_pkg::RST_CTRL_C;
         event_mask_low <= mcm_pkg::RST_MASK;
         event_mask_high <= mcm_pkg::RST_MASK;
      end else if (wr_en) begin
         case (addr)
            mcm_pkg::ADDR_CTRL_A: ctrl_a <= wdata;
            mcm_pkg::ADDR_CTRL_B: conversion_control_b <= wdata;
            mcm_pkg::ADDR_CTRL_C: conversion_control_c <= wdata;
            mcm_pkg::ADDR_MASK_LO: event_mask_low <= wdata;
            mcm_pkg::ADDR_MASK_HI: event_mask_high <= wdata;
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // read port
   // ***************************************************************
   // read returns stored bytes, reserved bits included
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rvalid <= rd_en;
         if (rd_en) begin
            case (addr)
               mcm_pkg::ADDR_CTRL_A: rdata <= ctrl_a;
               mcm_pkg::ADDR_CTRL_B: rdata <= conversion_control_b;
               mcm_pkg::ADDR_CTRL_C: rdata <= conversion_control_c;
               mcm_pkg::ADDR_MASK_LO: rdata <= event_mask_low;
               mcm_pkg::ADDR_MASK_HI: rdata <= event_mask_high;
               default: rdata <= 8'h00;
            endcase
         end
      end
   end

   // ***************************************************************
   // conversion target
   // ***************************************************************
   // decode select code and pin-pair field into target
   always_comb begin
      logic [3:0] sel;
      logic [1:0] pair;
      sel = conversion_control_b[mcm_pkg::B_SEL_LO +: 4];
      pair = ctrl_a[mcm_pkg::A_PAIR_LO +: 2];
      if (sel == mcm_pkg::CH_EXT_OR_ANALOG_INPUT_ONE) begin
         if (pair == mcm_pkg::PAIR_DIODE) begin
            next_target = mcm_pkg::TGT_EXT_DIODE;
         end else if (pair == mcm_pkg::PAIR_ANALOG) begin
            next_target = mcm_pkg::TGT_ANALOG_INPUT_ONE;
         end else begin
            next_target = mcm_pkg::TGT_NONE;
         end
      end else if (sel < mcm_pkg::CH_EXT_OR_ANALOG_INPUT_ONE) begin
         next_target = sel;
      end else if (sel <= mcm_pkg::CH_LAST) begin
         next_target = sel + 4'h1;
      end else begin
         next_target = mcm_pkg::TGT_NONE; // reserved codes
      end
   end

   // mode outputs registered from the configuration
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         conv_run <= 1'b0;
         conv_single <= 1'b0;
         conv_target <= mcm_pkg::CH_SUPPLY;
         avg_samples <= mcm_pkg::AVG_COUNT;
         fast_speed <= 1'b0;
         diode_filter_bypass <= 1'b0;
         ref_is_supply <= 1'b0;
      end else begin
         conv_run <= ctrl_a[mcm_pkg::A_MON_EN];
         conv_single <= conversion_control_b[mcm_pkg::B_SINGLE];
         conv_target <= next_target;
         avg_samples <= conversion_control_b[mcm_pkg::B_AVG_DIS] ? 5'h01
                        : mcm_pkg::AVG_COUNT;
         fast_speed <= conversion_control_c[mcm_pkg::C_FAST];
         diode_filter_bypass <= conversion_control_c[mcm_pkg::C_FAST];
         ref_is_supply <= conversion_control_c[mcm_pkg::C_REF_VDD];
      end
   end

   // ***************************************************************
   // adc clock
   // ***************************************************************
   // normal half period needs 26 bits, so the divider is sized for it
   mcm_adc_clk #(.CW(26)) u_adc_clk (
      .clock(clock),
      .nrst(nrst),
      .run(conv_run),
      .half(fast_speed ? 26'(mcm_pkg::ADC_FAST_HALF) : 26'(mcm_pkg::ADC_NORM_HALF)),
      .adc_clk(adc_clk)
   );

   // ***************************************************************
   // serial clock timeout
   // ***************************************************************
   // count cycles with scl unchanged inside a transaction
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         scl_q <= 1'b1; // serial clock idles high
         to_cnt <= '0;
         xfer_abort <= 1'b0;
      end else begin
         scl_q <= scl_in;
         xfer_abort <= 1'b0;
         if (!conversion_control_b[mcm_pkg::B_TO_EN] || !xfer_active || scl_q != scl_in) begin
            to_cnt <= '0;
         end else if (to_cnt >= 32'(TIMEOUT_CYCLES - 1)) begin
            to_cnt <= '0;
            xfer_abort <= 1'b1;
         end else begin
            to_cnt <= to_cnt + 32'h1;
         end
      end
   end

   // ***************************************************************
   // interrupt pin
   // ***************************************************************
   // unmasked events drive the pin at the chosen polarity
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         int_out <= 1'b1;
         int_oe <= 1'b0;
      end else begin
         int_oe <= ~ctrl_a[mcm_pkg::A_INT_DIS];
         int_out <= (|(events & ~mask_all)) ~^ ctrl_a[mcm_pkg::A_INT_POL]
                    ? 1'b1 : 1'b0;
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   sequence s_swrst;
      wr_en && addr == mcm_pkg::ADDR_CTRL_B && wdata[mcm_pkg::B_SW_RST];
   endsequence
   a_sw_reset_defaults: assert property (@(posedge clock) disable iff (!nrst)
      s_swrst |=> conversion_control_b == 8'h00 && event_mask_low == 8'h00
      && event_mask_high == 8'h00 && conversion_control_c == 8'h08 && ctrl_a == 8'h08)
      else $error("software reset missed");
   a_masked_quiet: assert property (@(posedge clock) disable iff (!nrst)
      (events & ~mask_all) == 13'h0 && !ctrl_a[6] |=> int_out)
      else $error("masked event drove pin");
   a_unmasked_fire: assert property (@(posedge clock) disable iff (!nrst)
      (events & ~mask_all) != 13'h0 |=> int_out == $past(ctrl_a[6]))
      else $error("unmasked event lost");
   a_avg_count: assert property (@(posedge clock) disable iff (!nrst)
      !conversion_control_b[5] && !$rose(conversion_control_b[5]) |=> avg_samples == 5'h10
      || $past(conversion_control_b[5])) else $error("averaging wrong");
   a_target_analog_input_two: assert property (@(posedge clock) disable iff (!nrst)
      conversion_control_b[3:0] == 4'h3 [*2] |-> conv_target == 4'h4)
      else $error("select decode wrong");
   a_pair_diode: assert property (@(posedge clock) disable iff (!nrst)
      (conversion_control_b[3:0] == 4'h2 && ctrl_a[2:1] == 2'h2) [*2] |-> conv_target == 4'h2)
      else $error("diode choice wrong");
   a_run_gate: assert property (@(posedge clock) disable iff (!nrst)
      !ctrl_a[0] [*2] |-> !conv_run) else $error("conversion while stopped");
   a_fast_bypass: assert property (@(posedge clock) disable iff (!nrst)
      fast_speed == diode_filter_bypass) else $error("filter bypass mismatch");
   a_read_back: assert property (@(posedge clock) disable iff (!nrst)
      rd_en && addr == mcm_pkg::ADDR_MASK_HI |=> rvalid && rdata == $past(event_mask_high))
      else $error("read back wrong");
   a_timeout_off: assert property (@(posedge clock) disable iff (!nrst)
      !conversion_control_b[6] [*2] |-> !xfer_abort) else $error("timeout while off");
endmodule : mcm_regs
`default_nettype wire

// *** mcm_host.sv ***
/*
 * host partner model: issues byte writes and reads on the bank's strobes.
 * assumes each task is called just after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module mcm_host (
   input wire logic clock,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   input wire logic rvalid,
   input wire logic [7:0] rdata
);
   // idle bus at time zero
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end
   // one byte write, strobe held to the taking edge then released
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clock);
      #1;
      wr_en = 1'b0;
      addr = ~a; // released bus shows no stale value
      wdata = ~d;
      @(posedge clock);
      #1;
   endtask : wr
   // one byte read, answer taken in the cycle after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      rd_en = 1'b1;
      addr = a;
      @(posedge clock);
      #1;
      rd_en = 1'b0;
      addr = ~a;
      ok = rvalid;
      d = rdata;
      @(posedge clock);
      #1;
   endtask : rd
endmodule : mcm_host
`default_nettype wire

// *** test_monitor_config_mask_regs.sv ***
/*
 * self-checking bench for the monitor configuration and mask bank.
 * assumes the bank and the host partner model compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module test_monitor_config_mask_regs;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic scl_in = 1'b1;
   logic xfer_active = 1'b0;
   logic [12:0] events = 13'h0000;
   logic wr_en, rd_en, rvalid, xfer_abort, int_out, int_oe, conv_run, conv_single;
   logic fast_speed, diode_filter_bypass, ref_is_supply, adc_clk;
   logic [7:0] addr, wdata, rdata;
   logic [3:0] conv_target;
   logic [4:0] avg_samples;
   int fail_count = 0;
   int checks_done = 0;
   always #5 clock = ~clock;
   mcm_regs #(.TIMEOUT_CYCLES(20)) DUT (.clock(clock), .nrst(nrst), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid),
      .scl_in(scl_in), .xfer_active(xfer_active), .xfer_abort(xfer_abort),
      .events(events), .int_out(int_out), .int_oe(int_oe), .conv_run(conv_run),
      .conv_single(conv_single), .conv_target(conv_target), .avg_samples(avg_samples),
      .fast_speed(fast_speed), .diode_filter_bypass(diode_filter_bypass),
      .ref_is_supply(ref_is_supply), .adc_clk(adc_clk));
   mcm_host host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata), .rvalid(rvalid), .rdata(rdata));
   // compare one value and count it
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   // read a register and compare answer pulse and data
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      host.rd(a, d, ok);
      chk({7'h0, ok}, 8'h01);
      chk(d, e);
   endtask : rdchk
   task automatic t_defaults;
      rdchk(mcm_pkg::ADDR_CTRL_A, 8'h08);
      rdchk(mcm_pkg::ADDR_CTRL_B, 8'h00);
      rdchk(mcm_pkg::ADDR_CTRL_C, 8'h08);
      rdchk(mcm_pkg::ADDR_MASK_LO, 8'h00);
      rdchk(mcm_pkg::ADDR_MASK_HI, 8'h00);
      rdchk(8'h1b, 8'h00);
      chk({7'h0, conv_run}, 8'h00);
      chk({3'h0, avg_samples}, 8'h10);
      chk({3'h0, conv_single, conv_target}, 8'h00);
      chk({6'h0, fast_speed, ref_is_supply}, 8'h00);
      // idle pin high and enabled, divider held low while stopped
      chk({5'h0, int_oe, int_out, adc_clk}, 8'h06);
      $display("defaults done");
   endtask : t_defaults
   // every defined select code in single mode, then round-robin
   task automatic t_channels;
      logic [3:0] e;
      for (int c = 0; c <= 9; c++) begin
         e = (c < 2) ? 4'(c) : (c == 2) ? mcm_pkg::TGT_ANALOG_INPUT_ONE : 4'(c + 1);
         // codes stay below the reserved range
         host.wr(mcm_pkg::ADDR_CTRL_B, 8'h10 | 8'(c));
         tick(1);
         chk({3'h0, conv_single, conv_target}, {4'h1, e});
      end
      host.wr(mcm_pkg::ADDR_CTRL_B, 8'h09);
      tick(1);
      chk({3'h0, conv_single, conv_target}, 8'h0a);
      host.wr(mcm_pkg::ADDR_CTRL_A, 8'h0d);
      host.wr(mcm_pkg::ADDR_CTRL_B, 8'h12);
      tick(1);
      chk({3'h0, conv_run, conv_target}, {4'h1, mcm_pkg::TGT_EXT_DIODE});
      $display("channels done");
   endtask : t_channels
   task automatic t_config;
      host.wr(mcm_pkg::ADDR_CTRL_B, 8'h20);
      tick(1);
      chk({2'h0, conv_single, avg_samples}, 8'h01);
      host.wr(mcm_pkg::ADDR_CTRL_C, 8'h19);
      tick(1);
      chk({5'h0, fast_speed, diode_filter_bypass, ref_is_supply}, 8'h07);
      rdchk(mcm_pkg::ADDR_CTRL_C, 8'h19);
      host.wr(mcm_pkg::ADDR_CTRL_C, 8'h08);
      tick(1);
      chk({5'h0, fast_speed, diode_filter_bypass, ref_is_supply}, 8'h00);
      $display("config done");
   endtask : t_config
   // each source passes unmasked and is stopped by its own bit
   task automatic t_masks;
      for (int i = 0; i < 13; i++) begin
         events = 13'h0001 << i;
         tick(3);
         chk({7'h0, int_out}, 8'h00);
         if (i < 8) host.wr(mcm_pkg::ADDR_MASK_LO, 8'h01 << i);
         else host.wr(mcm_pkg::ADDR_MASK_HI, 8'h01 << (i - 8));
         tick(1);
         chk({7'h0, int_out}, 8'h01);
         host.wr(i < 8 ? mcm_pkg::ADDR_MASK_LO : mcm_pkg::ADDR_MASK_HI, 8'h00);
      end
      host.wr(mcm_pkg::ADDR_CTRL_A, 8'h4d);
      tick(1);
      chk({6'h0, int_oe, int_out}, 8'h03);
      host.wr(mcm_pkg::ADDR_CTRL_A, 8'h6d);
      tick(1);
      chk({7'h0, int_oe}, 8'h00);
      events = 13'h0000;
      $display("masks done");
   endtask : t_masks
   task automatic t_timeout;
      int n;
      int hits;
      xfer_active = 1'b1;
      host.wr(mcm_pkg::ADDR_CTRL_B, 8'h40);
      hits = 0;
      for (n = 0; n < 60; n++) begin
         if (n % 10 == 0) scl_in = ~scl_in;
         tick(1);
         hits += int'(xfer_abort);
      end
      chk(8'(hits), 8'h00);
      // fresh scl edge, then twenty steady cycles and the registered pulse
      scl_in = ~scl_in;
      n = 0;
      while (xfer_abort !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      chk(8'(n), 8'h15);
      if (n == 40) close_out();
      host.wr(mcm_pkg::ADDR_CTRL_B, 8'h00);
      hits = 0;
      repeat (60) begin
         tick(1);
         hits += int'(xfer_abort);
      end
      chk(8'(hits), 8'h00);
      xfer_active = 1'b0;
      $display("timeout done");
   endtask : t_timeout
   task automatic t_swreset;
      host.wr(mcm_pkg::ADDR_MASK_LO, 8'h5a);
      host.wr(mcm_pkg::ADDR_MASK_HI, 8'h15);
      host.wr(mcm_pkg::ADDR_CTRL_C, 8'h19);
      host.wr(mcm_pkg::ADDR_CTRL_B, 8'h35);
      host.wr(mcm_pkg::ADDR_CTRL_B, 8'h80);
      rdchk(mcm_pkg::ADDR_CTRL_A, 8'h08);
      rdchk(mcm_pkg::ADDR_CTRL_B, 8'h00);
      rdchk(mcm_pkg::ADDR_CTRL_C, 8'h08);
      rdchk(mcm_pkg::ADDR_MASK_LO, 8'h00);
      rdchk(mcm_pkg::ADDR_MASK_HI, 8'h00);
      chk({6'h0, int_oe, conv_run}, 8'h02);
      $display("software reset done");
   endtask : t_swreset
   // main sequence
   initial begin
      repeat (5) @(posedge clock);
      #1;
      nrst = 1'b1;
      tick(1);
      t_defaults();
      t_channels();
      t_config();
      t_masks();
      t_timeout();
      t_swreset();
      close_out();
   end
endmodule : test_monitor_config_mask_regs
`default_nettype wire
